/* verilog/scid_pkg.sv */
// Package with test port constants, states and carrier types
package scid_pkg;

  // Test access port controller states
  typedef enum logic [3:0] {
    TLR, RTI, SELDR, CAPDR, SHDR, EX1DR, PDR, EX2DR, UPDR,
    SELIR, CAPIR, SHIR, EX1IR, PIR, EX2IR, UPIR
  } scid_tap_e;

  // Instruction register layout and codes
  localparam int         IR_W        = 4;
  localparam logic [3:0] INS_IDENT   = 4'h1;
  localparam logic [3:0] INS_BYPASS  = 4'hf;
  localparam logic [1:0] IR_CAPTURE  = 2'h1;
  localparam int         ID_W        = 32;
  // Identification value, arbitrary neutral value
  localparam logic [31:0] ID_VALUE   = 32'h0000_1001;

  // Synchroniser depth for pins
  localparam int SYNC_STAGES = 3;

  // Sampled link pins travel together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } scid_pins_s;

endpackage : scid_pkg

/* verilog/scid_sync.sv */
// Three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module scid_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Pin side
  input  wire logic [WIDTH-1:0] pinIn,
  // Filtered level
  output logic      [WIDTH-1:0] pinOut
);

  // Refuse an empty bus at elaboration
  if (WIDTH < 1) begin : g_badWidth
    $error("scid_sync WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [WIDTH-1:0] nxt_out;

  // A bit changes only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
    end
  end

  // First stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end else begin
      s1_ff  <= pinIn;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign pinOut = out_ff;

endmodule : scid_sync

/* verilog/scid_tap.sv */
// Boundary-scan test port with the identification path defect
// Functional notes
// - Identification shift feeds constant one instead of serial input.
// - Upstream bits passing through emerge as all ones.
// - Downstream members update with all ones under identification.
// - Test-Logic-Reset selects the identification instruction.
// - Alone in chain, identification value reads out correctly.
// - Identification register never takes scanned-in data.
`timescale 1ns/1ps
module scid_tap (
  // Core clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Test port pins
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  input  wire logic trstN,
  // Serial output pin, driven while shifting
  output logic      tdo,
  output logic      tdoOe,
  // Observation
  output logic      identSel,
  output logic      tapReset
);

  logic rstS1_ff, rstS2_ff;
  wire  rstCore = rstS2_ff;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstS1_ff <= 1'b0;
      rstS2_ff <= 1'b0;
    end else begin
      rstS1_ff <= 1'b1;
      rstS2_ff <= rstS1_ff;
    end
  end

  scid_pkg::scid_pins_s pinRaw, pinSync;
  assign pinRaw = '{tck: tck, tms: tms, tdi: tdi};

  // Test reset pin goes through the same filter width 1
  logic trstSyncN;

  scid_sync #(.WIDTH(3)) uPins (
    .core_clk (core_clk),
    .rst_n    (rstCore),
    .pinIn    (pinRaw),
    .pinOut   (pinSync)
  );

  scid_sync #(.WIDTH(1)) uTrst (
    .core_clk (core_clk),
    .rst_n    (rstCore),
    .pinIn    (trstN),
    .pinOut   (trstSyncN)
  );

  // Edge detection on the filtered test clock
  logic tckOld_ff;
  wire  tckRise = pinSync.tck & ~tckOld_ff;
  wire  tckFall = ~pinSync.tck & tckOld_ff;

  scid_pkg::scid_tap_e     state_ff, nxt_state;
  logic [3:0]              ir_ff, irSh_ff, nxt_ir, nxt_irSh;
  logic [31:0]             idSh_ff, nxt_idSh;
  logic                    byp_ff, nxt_byp;
  logic                    tdo_ff, nxt_tdo, oe_ff, nxt_oe;

  // State advance on rising test clock
  always_comb begin
    nxt_state = state_ff;
    if (tckRise) begin
      case (state_ff)
        scid_pkg::TLR:   nxt_state = pinSync.tms ? scid_pkg::TLR   : scid_pkg::RTI;
        scid_pkg::RTI:   nxt_state = pinSync.tms ? scid_pkg::SELDR : scid_pkg::RTI;
        scid_pkg::SELDR: nxt_state = pinSync.tms ? scid_pkg::SELIR : scid_pkg::CAPDR;
        scid_pkg::CAPDR: nxt_state = pinSync.tms ? scid_pkg::EX1DR : scid_pkg::SHDR;
        scid_pkg::SHDR:  nxt_state = pinSync.tms ? scid_pkg::EX1DR : scid_pkg::SHDR;
        scid_pkg::EX1DR: nxt_state = pinSync.tms ? scid_pkg::UPDR  : scid_pkg::PDR;
        scid_pkg::PDR:   nxt_state = pinSync.tms ? scid_pkg::EX2DR : scid_pkg::PDR;
        scid_pkg::EX2DR: nxt_state = pinSync.tms ? scid_pkg::UPDR  : scid_pkg::SHDR;
        scid_pkg::UPDR:  nxt_state = pinSync.tms ? scid_pkg::SELDR : scid_pkg::RTI;
        scid_pkg::SELIR: nxt_state = pinSync.tms ? scid_pkg::TLR   : scid_pkg::CAPIR;
        scid_pkg::CAPIR: nxt_state = pinSync.tms ? scid_pkg::EX1IR : scid_pkg::SHIR;
        scid_pkg::SHIR:  nxt_state = pinSync.tms ? scid_pkg::EX1IR : scid_pkg::SHIR;
        scid_pkg::EX1IR: nxt_state = pinSync.tms ? scid_pkg::UPIR  : scid_pkg::PIR;
        scid_pkg::PIR:   nxt_state = pinSync.tms ? scid_pkg::EX2IR : scid_pkg::PIR;
        scid_pkg::EX2IR: nxt_state = pinSync.tms ? scid_pkg::UPIR  : scid_pkg::SHIR;
        scid_pkg::UPIR:  nxt_state = pinSync.tms ? scid_pkg::SELDR : scid_pkg::RTI;
        default:         nxt_state = scid_pkg::TLR;
      endcase
    end
    if (!trstSyncN) nxt_state = scid_pkg::TLR;
  end

  wire isIdent = (ir_ff == scid_pkg::INS_IDENT);

  // Shift, capture and update of instruction and data paths
  always_comb begin
    nxt_ir   = ir_ff;
    nxt_irSh = irSh_ff;
    nxt_idSh = idSh_ff;
    nxt_byp  = byp_ff;
    nxt_tdo  = tdo_ff;
    nxt_oe   = oe_ff;
    if (state_ff == scid_pkg::TLR) begin
      nxt_ir = scid_pkg::INS_IDENT;
    end
    if (tckRise) begin
      case (state_ff)
        scid_pkg::CAPIR: nxt_irSh = {2'h0, scid_pkg::IR_CAPTURE};
        scid_pkg::SHIR:  nxt_irSh = {pinSync.tdi, irSh_ff[3:1]};
        // Capture reloads the fixed value; nothing scanned is kept
        scid_pkg::CAPDR: begin
          nxt_idSh = scid_pkg::ID_VALUE;
          nxt_byp  = 1'b0;
        end
        scid_pkg::SHDR: begin
          if (isIdent) begin
            // Constant one replaces serial input; follow
            nxt_idSh = {1'b1, idSh_ff[31:1]};
          end else begin
            nxt_byp = pinSync.tdi;
          end
        end
        default: nxt_irSh = irSh_ff;
      endcase
    end
    if (tckFall) begin
      if (state_ff == scid_pkg::UPIR) nxt_ir = irSh_ff;
      // Serial output from shift register, changing on falling clock
      nxt_oe = (state_ff == scid_pkg::SHDR) || (state_ff == scid_pkg::SHIR);
      if (state_ff == scid_pkg::SHIR)      nxt_tdo = irSh_ff[0];
      else if (isIdent)                    nxt_tdo = idSh_ff[0];
      else                                 nxt_tdo = byp_ff;
    end
  end

  // Registers of the test port
  always_ff @(posedge core_clk or negedge rstCore) begin
    if (!rstCore) begin
      tckOld_ff <= 1'b0;
      state_ff  <= scid_pkg::TLR;
      ir_ff     <= scid_pkg::INS_IDENT;
      irSh_ff   <= 4'h0;
      idSh_ff   <= 32'h0000_0000;
      byp_ff    <= 1'b0;
      tdo_ff    <= 1'b0;
      oe_ff     <= 1'b0;
    end else begin
      tckOld_ff <= pinSync.tck;
      state_ff  <= nxt_state;
      ir_ff     <= nxt_ir;
      irSh_ff   <= nxt_irSh;
      idSh_ff   <= nxt_idSh;
      byp_ff    <= nxt_byp;
      tdo_ff    <= nxt_tdo;
      oe_ff     <= nxt_oe;
    end
  end

  logic identSel_ff, tapReset_ff;
  always_ff @(posedge core_clk or negedge rstCore) begin
    if (!rstCore) begin
      identSel_ff <= 1'b1;
      tapReset_ff <= 1'b1;
    end else begin
      identSel_ff <= isIdent;
      tapReset_ff <= (state_ff == scid_pkg::TLR);
    end
  end

  assign tdo      = tdo_ff;
  assign tdoOe    = oe_ff;
  assign identSel = identSel_ff;
  assign tapReset = tapReset_ff;

  // Checks
  property p_inject_one;
    @(posedge core_clk) disable iff (!rstCore)
      (tckRise && state_ff == scid_pkg::SHDR && isIdent) |=> idSh_ff[31];
  endproperty
  a_inject_one: assert property (p_inject_one) else $error("ident shift did not inject one");

  property p_reset_ident;
    @(posedge core_clk) disable iff (!rstCore)
      (state_ff == scid_pkg::TLR) |=> isIdent;
  endproperty
  a_reset_ident: assert property (p_reset_ident) else $error("reset did not select ident");

  property p_capture_value;
    @(posedge core_clk) disable iff (!rstCore)
      (tckRise && state_ff == scid_pkg::CAPDR) |=> idSh_ff == scid_pkg::ID_VALUE;
  endproperty
  a_capture_value: assert property (p_capture_value) else $error("capture value wrong");

  property p_tms_reset;
    @(posedge core_clk) disable iff (!rstCore)
      (tckRise && state_ff == scid_pkg::SELIR && pinSync.tms && trstSyncN) |=> state_ff == scid_pkg::TLR;
  endproperty
  a_tms_reset: assert property (p_tms_reset) else $error("select-ir with tms high missed reset");

  property p_hold_state;
    @(posedge core_clk) disable iff (!rstCore)
      (!tckRise && trstSyncN) |=> $stable(state_ff);
  endproperty
  a_hold_state: assert property (p_hold_state) else $error("state moved without clock edge");

  property p_oe_shift;
    @(posedge core_clk) disable iff (!rstCore)
      (tckFall && state_ff == scid_pkg::SHDR) |=> tdoOe;
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("output not enabled in shift");

  property p_out_ones;
    @(posedge core_clk) disable iff (!rstCore)
      (tckFall && isIdent && state_ff == scid_pkg::SHDR && idSh_ff == 32'hffff_ffff) |=> tdo;
  endproperty
  a_out_ones: assert property (p_out_ones) else $error("passed bits not all ones");

  property p_ir_update;
    @(posedge core_clk) disable iff (!rstCore)
      (tckFall && state_ff == scid_pkg::UPIR) |=> ir_ff == $past(irSh_ff);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("instruction not updated");

  c_ident_shift: cover property (@(posedge core_clk) tckRise && state_ff == scid_pkg::SHDR && isIdent);
  c_bypass_shift: cover property (@(posedge core_clk) tckRise && state_ff == scid_pkg::SHDR && !isIdent);
  c_ir_update: cover property (@(posedge core_clk) tckFall && state_ff == scid_pkg::UPIR);
  c_dr_pause: cover property (@(posedge core_clk) tckRise && state_ff == scid_pkg::PDR);

endmodule : scid_tap

/* dv/scid_ctl_model.sv */
// Scan controller model that drives the test port pins
`timescale 1ns/1ps
module scid_ctl_model (
  // Pins toward the test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  // Serial return and its enable
  input  wire logic tdo,
  input  wire logic tdoOe
);
  logic lastTdo;
  int   pauseAt = -1;

  // Clock stands still low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // 64 ns period; the 30 ns tail lets the filtered serial output settle before sampling
  // A switched-off output reads as its opposite, so a read outside shifting shows up
  // One test clock
  task automatic clk(input logic m, input logic d);
    tms = m;
    tdi = d;
    #2 tck = 1'b1;
    #32 tck = 1'b0;
    #30 lastTdo = tdoOe ? tdo : ~tdo;
  endtask : clk

  // One data or instruction scan from idle back to idle, optionally parked in pause
  // The device is alone here, so no downstream member is ever accessed
  // Lone device scan
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    dout = '0;
    clk(1'b1, 1'b0);
    if (ir) clk(1'b1, 1'b0);
    clk(1'b0, 1'b0);
    clk(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      dout[i] = lastTdo;
      if (i == pauseAt) begin
        // Leave shifting, wait in pause, then come back to shifting
        clk(1'b1, din[i]);
        clk(1'b0, 1'b0);
        clk(1'b0, 1'b0);
        clk(1'b1, 1'b0);
        clk(1'b0, 1'b0);
      end else begin
        clk(i == n - 1, din[i]);
      end
    end
    clk(1'b1, 1'b0);
    // Serial line no longer holds the last value between frames
    clk(1'b0, ~din[n-1]);
  endtask : scan
endmodule : scid_ctl_model

/* dv/scid_tap_tb_top.sv */
// Testbench for the identification path of the test port
`timescale 1ns/1ps
module scid_tap_tb_top;
  logic        coreClk = 1'b0;
  logic        rstN    = 1'b0;
  logic        trstN   = 1'b1;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdoOe;
  logic        identSel;
  logic        tapReset;
  int          badCount = 0;
  int          cmpCount = 0;
  int          cycles   = 0;
  logic [31:0] seed     = 32'h0000_003f;
  logic [63:0] din;
  logic [63:0] dout;

  // 200 MHz core clock
  always #2.5 coreClk = ~coreClk;

  scid_tap i_scid_tap (
    .core_clk (coreClk),
    .rst_n    (rstN),
    .tck      (tck),
    .tms      (tms),
    .tdi      (tdi),
    .trstN    (trstN),
    .tdo      (tdo),
    .tdoOe    (tdoOe),
    .identSel (identSel),
    .tapReset (tapReset)
  );

  scid_ctl_model i_scid_ctl_model (
    .tck (tck),
    .tms (tms),
    .tdi   (tdi),
    .tdo   (tdo),
    .tdoOe (tdoOe)
  );

  // Xorshift source, fixed start keeps runs repeatable
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Identification value, then injected ones behind it
  function automatic logic [63:0] expIdent();
    return {32'hffff_ffff, scid_pkg::ID_VALUE};
  endfunction : expIdent

  // Bypass bit captures zero, then input delayed by one
  function automatic logic [63:0] expBypass(input logic [63:0] d);
    return {48'h0, d[14:0], 1'b0};
  endfunction : expBypass

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : giveVerdict

  task automatic loadIr(input logic [3:0] code);
    i_scid_ctl_model.scan(1'b1, 4, {60'h0, code}, dout);
    check("irCapture", 64'(dout[1:0]), 64'(scid_pkg::IR_CAPTURE));
    check("tdoOeIdle", 64'(tdoOe), 64'h0);
  endtask : loadIr

  // Hang guard well above the longest expected run
  always @(posedge coreClk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      badCount++;
      giveVerdict();
    end
  end

  initial begin
    repeat (8) @(posedge coreClk);
    #1 rstN = 1'b1;
    repeat (10) @(posedge coreClk);
    check("tapReset", 64'(tapReset), 64'h1);
    check("identSel", 64'(identSel), 64'h1);
    i_scid_ctl_model.clk(1'b0, 1'b0);
    check("tapReset", 64'(tapReset), 64'h0);
    // All-zero input first, then random, the last one parked in pause; the ID must never change
    for (int k = 0; k < 3; k++) begin
      din = (k == 0) ? 64'h0 : {rnd(), rnd()};
      i_scid_ctl_model.pauseAt = (k == 2) ? 20 : -1;
      i_scid_ctl_model.scan(1'b0, 64, din, dout);
      check("identScan", dout, expIdent());
    end
    loadIr(scid_pkg::INS_BYPASS);
    check("identSel", 64'(identSel), 64'h0);
    for (int k = 0; k < 3; k++) begin
      din = {rnd(), rnd()};
      i_scid_ctl_model.pauseAt = (k == 1) ? 7 : -1;
      i_scid_ctl_model.scan(1'b0, 16, din, dout);
      check("bypassScan", dout, expBypass(din));
    end
    // Instruction load parked once in its pause state
    i_scid_ctl_model.pauseAt = 1;
    loadIr(scid_pkg::INS_IDENT);
    i_scid_ctl_model.pauseAt = -1;
    check("identSel", 64'(identSel), 64'h1);
    din = {rnd(), rnd()};
    i_scid_ctl_model.scan(1'b0, 64, din, dout);
    check("identUpdate", dout, expIdent());
    // Five high mode-select clocks reach reset from anywhere
    loadIr(scid_pkg::INS_BYPASS);
    repeat (5) i_scid_ctl_model.clk(1'b1, 1'b0);
    check("tmsReset", {62'h0, tapReset, identSel}, 64'h3);
    i_scid_ctl_model.clk(1'b0, 1'b0);
    // Test reset pin forces reset state and default instruction
    loadIr(scid_pkg::INS_BYPASS);
    @(posedge coreClk);
    #1 trstN = 1'b0;
    repeat (10) @(posedge coreClk);
    check("pinReset", {62'h0, tapReset, identSel}, 64'h3);
    #1 trstN = 1'b1;
    repeat (10) @(posedge coreClk);
    giveVerdict();
  end
endmodule : scid_tap_tb_top
